/* File: rtl/abwp_bridge.sv */
// AHB-Lite to APB4 bridge with a peripheral write-protect controller
`timescale 1ns/1ps
module abwp_bridge
#(
  parameter int PERIPH_IDX_LSB = 10,
  parameter int PERIPH_IDX_W   = 5,
  parameter logic [31:0] CTRL_A_BASE = 32'h4000_0000,
  parameter logic [31:0] CTRL_C_BASE = 32'h4200_0000,
  parameter logic [31:0] GROUP_A_BASE = 32'h4000_0000,
  parameter logic [31:0] GROUP_C_BASE = 32'h4200_0000
) (
  // Clock and reset; the clock is the gated bridge bus clock
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [3:0]  hprot,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // APB4 master
  output logic             psel,
  output logic             penable,
  output logic      [31:0] paddr,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  output logic      [2:0]  pprot,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  import abwp_pkg::*;

  // Elaboration check: the index must reach bit 19 and sit under the group compare bits
  if (PERIPH_IDX_W != 5 || PERIPH_IDX_LSB < 8
      || PERIPH_IDX_LSB + PERIPH_IDX_W > 16) begin : g_bad_idx
    $error("peripheral index field does not fit the protection groups");
  end

  abwp_state_t state_ff;
  abwp_req_t   req_ff;
  logic [31:0] protect_a;
  logic [31:0] protect_c;
  logic [31:0] rdata_ff;
  logic [3:0]  strobe;
  logic        take;
  logic        is_ctrl_a;
  logic        is_ctrl_c;
  logic        is_ctrl;
  logic        blocked;
  logic        wr_clear_a;
  logic        wr_set_a;
  logic        wr_clear_c;
  logic        wr_set_c;
  logic [PERIPH_IDX_W-1:0] periph_idx;

  assign take = hsel && hready && (htrans == ABWP_HTRANS_NONSEQ || htrans == ABWP_HTRANS_SEQ);

  // Request capture at the AHB address phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_ff <= '0;
    end else if (take) begin
      req_ff <= '{addr: haddr, write: hwrite, size: hsize, prot: hprot};
    end
  end

  // Controller windows: offsets only decoded inside the controller page
  assign is_ctrl_a = (req_ff.addr[31:8] == CTRL_A_BASE[31:8]);
  assign is_ctrl_c = (req_ff.addr[31:8] == CTRL_C_BASE[31:8]);
  assign is_ctrl   = is_ctrl_a || is_ctrl_c;
  assign periph_idx = req_ff.addr[PERIPH_IDX_LSB +: PERIPH_IDX_W];

  always_comb begin
    blocked = 1'b0;
    if (req_ff.write && !is_ctrl) begin
      if (req_ff.addr[31:16] == GROUP_A_BASE[31:16]) begin
        blocked = protect_a[periph_idx];
      end else if (req_ff.addr[31:16] == GROUP_C_BASE[31:16]) begin
        blocked = protect_c[periph_idx];
      end
    end
  end

  // Bridge sequencer; one state covers the merged setup and access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= ABWP_IDLE;
    end else begin
      case (state_ff)
        ABWP_IDLE: begin
          if (take) begin
            state_ff <= ABWP_ACCESS;
          end
        end
        ABWP_ACCESS: begin
          if (blocked) begin
            state_ff <= ABWP_ERR1;
          end else if (is_ctrl) begin
            state_ff <= ABWP_IDLE;
          end else if (pready) begin
            state_ff <= pslverr ? ABWP_ERR1 : ABWP_IDLE;
          end
        end
        ABWP_ERR1: state_ff <= ABWP_ERR2;
        ABWP_ERR2: state_ff <= take ? ABWP_ACCESS : ABWP_IDLE;
        default:   state_ff <= ABWP_IDLE;
      endcase
    end
  end

  abwp_strobe_gen u_strobe (
    .addr_lo (req_ff.addr[1:0]),
    .size    (req_ff.size),
    .strobe  (strobe)
  );

  // merged address and data cycle: psel and penable rise together
  assign psel    = (state_ff == ABWP_ACCESS) && !is_ctrl && !blocked;
  assign penable = psel;
  assign paddr   = req_ff.addr;
  assign pwrite  = req_ff.write;
  assign pwdata  = hwdata;
  assign pstrb   = strobe;
  // protection attributes: privileged from hprot[1], data/instr from hprot[0]
  assign pprot   = {~req_ff.prot[0], 1'b0, req_ff.prot[1]};

  // Controller register writes
  // group A clear offset
  assign wr_clear_a = (state_ff == ABWP_ACCESS) && is_ctrl_a && req_ff.write
                      && req_ff.addr[7:0] == ABWP_OFS_CLEAR;
  assign wr_set_a   = (state_ff == ABWP_ACCESS) && is_ctrl_a && req_ff.write
                      && req_ff.addr[7:0] == ABWP_OFS_SET;
  assign wr_clear_c = (state_ff == ABWP_ACCESS) && is_ctrl_c && req_ff.write
                      && req_ff.addr[7:0] == ABWP_OFS_CLEAR;
  assign wr_set_c   = (state_ff == ABWP_ACCESS) && is_ctrl_c && req_ff.write
                      && req_ff.addr[7:0] == ABWP_OFS_SET;

  abwp_protect_reg #(
    .RESET_VAL (ABWP_RST_GROUP_A),
    .IMPL_MASK (ABWP_MASK_GROUP_A)
  ) u_group_a (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .wr_clear   (wr_clear_a),
    .wr_set     (wr_set_a),
    .wr_data    (hwdata),
    .protect_ff (protect_a)
  );

  abwp_protect_reg #(
    .RESET_VAL (ABWP_RST_GROUP_C),
    .IMPL_MASK (ABWP_MASK_GROUP_C | ABWP_RST_GROUP_C)
  ) u_group_c (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .wr_clear   (wr_clear_c),
    .wr_set     (wr_set_c),
    .wr_data    (hwdata),
    .protect_ff (protect_c)
  );

  // Read data register; both offsets show the same state, others read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (state_ff == ABWP_ACCESS) begin
      if (is_ctrl) begin
        if (req_ff.addr[7:0] == ABWP_OFS_CLEAR || req_ff.addr[7:0] == ABWP_OFS_SET) begin
          rdata_ff <= is_ctrl_a ? protect_a : protect_c;
        end else begin
          rdata_ff <= 32'h0000_0000;
        end
      end else if (pready) begin
        rdata_ff <= prdata;
      end
    end
  end
  assign hrdata = rdata_ff;

  // single clock, AHB ready held low in the access state and raised the cycle after an APB ready without pslverr, two cycles after one with it
  always_comb begin
    hreadyout = 1'b1;
    hresp     = 1'b0;
    case (state_ff)
      ABWP_ACCESS: hreadyout = 1'b0;
      ABWP_ERR1: begin
        hreadyout = 1'b0;
        hresp     = 1'b1;
      end
      ABWP_ERR2: hresp = 1'b1;
      default: begin
        hreadyout = 1'b1;
        hresp     = 1'b0;
      end
    endcase
  end

  // Assertions
  property p_err_two_cycle;
    @(posedge sys_clk) disable iff (sys_rst)
      state_ff == ABWP_ERR1 |-> hresp && !hreadyout ##1 hresp && hreadyout;
  endproperty
  a_err_two_cycle: assert property (p_err_two_cycle) else $error("error response not two cycles");

  property p_blocked_no_apb;
    @(posedge sys_clk) disable iff (sys_rst)
      blocked && state_ff == ABWP_ACCESS |-> !psel ##1 state_ff == ABWP_ERR1;
  endproperty
  a_blocked_no_apb: assert property (p_blocked_no_apb) else $error("protected write reached APB");

  property p_merged_cycle;
    @(posedge sys_clk) disable iff (sys_rst)
      psel |-> penable;
  endproperty
  a_merged_cycle: assert property (p_merged_cycle) else $error("separate setup phase seen");

  property p_one_cycle_apb;
    @(posedge sys_clk) disable iff (sys_rst)
      psel && pready && !pslverr |=> state_ff == ABWP_IDLE;
  endproperty
  a_one_cycle_apb: assert property (p_one_cycle_apb) else $error("unwaited transfer did not end");

  property p_strobe_byte;
    @(posedge sys_clk) disable iff (sys_rst)
      psel && req_ff.size == 3'h0 |-> $onehot(pstrb);
  endproperty
  a_strobe_byte: assert property (p_strobe_byte) else $error("byte lane not one-hot");

  property p_clear_ones;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_clear_a |=> (protect_a & $past(hwdata)) == 32'h0;
  endproperty
  a_clear_ones: assert property (p_clear_ones) else $error("clear left protection on");

  property p_clear_zeros;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_clear_a |=> (protect_a & ~$past(hwdata)) == ($past(protect_a) & ~$past(hwdata));
  endproperty
  a_clear_zeros: assert property (p_clear_zeros) else $error("clear changed other bits");

  property p_set_ones;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_set_c |=> (protect_c & $past(hwdata) & ABWP_MASK_GROUP_C)
                   == ($past(hwdata) & ABWP_MASK_GROUP_C);
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("set failed to protect");

  property p_reset_value;
    @(posedge sys_clk) $fell(sys_rst) |-> protect_a == ABWP_RST_GROUP_A;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("group A reset value wrong");

  property p_reset_group_c;
    @(posedge sys_clk) $fell(sys_rst) |-> protect_c == ABWP_RST_GROUP_C;
  endproperty
  a_reset_group_c: assert property (p_reset_group_c) else $error("group C reset wrong");

  property p_set_ones_a;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_set_a |=> (protect_a & $past(hwdata) & ABWP_MASK_GROUP_A)
                   == ($past(hwdata) & ABWP_MASK_GROUP_A);
  endproperty
  a_set_ones_a: assert property (p_set_ones_a) else $error("group A set failed");

  // Register accesses never wait on the peripheral side
  property p_ctrl_single;
    @(posedge sys_clk) disable iff (sys_rst)
      state_ff == ABWP_ACCESS && is_ctrl |=> hreadyout && !hresp;
  endproperty
  a_ctrl_single: assert property (p_ctrl_single) else $error("register access not single");

  // A waiting peripheral must see the same request until it answers
  property p_wait_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      psel && !pready |=> psel && $stable(paddr) && $stable(pwrite) && $stable(pstrb);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("APB request changed in wait");

  c_blocked_write: cover property (@(posedge sys_clk) blocked && state_ff == ABWP_ACCESS);
  c_waited: cover property (@(posedge sys_clk) psel ##1 psel ##1 psel && pready);
  c_clear: cover property (@(posedge sys_clk) wr_clear_a && hwdata[ABWP_BIT_SERVICE_UNIT]);
  c_slverr: cover property (@(posedge sys_clk) psel && pready && pslverr);
endmodule

/* File: rtl/abwp_pkg.sv */
// Shared constants and carriers for the bridge with write protection
package abwp_pkg;
  // Controller register offsets
  localparam logic [7:0]  ABWP_OFS_CLEAR = 8'h00;
  localparam logic [7:0]  ABWP_OFS_SET   = 8'h04;
  // Reset values of the protection state
  localparam logic [31:0] ABWP_RST_GROUP_A = 32'h0000_0002;
  localparam logic [31:0] ABWP_RST_GROUP_C = 32'h0080_0000;
  // Implemented bits of each protection group; group C also implements its reset bit
  localparam logic [31:0] ABWP_MASK_GROUP_A = 32'h0000_004e;
  localparam logic [31:0] ABWP_MASK_GROUP_C = 32'h000f_fffe;
  // Group A field positions
  localparam int ABWP_BIT_SERVICE_UNIT = 1;
  localparam int ABWP_BIT_NONVOLATILE  = 2;
  localparam int ABWP_BIT_PORT_BLOCK   = 3;
  localparam int ABWP_BIT_TRACE_BUFFER = 6;
  // Group C field positions
  localparam int ABWP_BIT_EVENT_ROUTER = 1;
  localparam int ABWP_BIT_SERIAL_LO    = 2;
  localparam int ABWP_BIT_TIMER_LO     = 8;
  localparam int ABWP_BIT_ADC          = 16;
  localparam int ABWP_BIT_TOUCH_SENSE  = 19;
  // AHB transfer types
  localparam logic [1:0] ABWP_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] ABWP_HTRANS_SEQ    = 2'b11;
  // Latched upstream request
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [2:0]  size;
    logic [3:0]  prot;
  } abwp_req_t;
  // Bridge states
  typedef enum logic [1:0] {ABWP_IDLE, ABWP_ACCESS, ABWP_ERR1, ABWP_ERR2} abwp_state_t;
endpackage

/* File: rtl/abwp_protect_reg.sv */
// One write-protect group with set and clear registers
`timescale 1ns/1ps
module abwp_protect_reg #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] IMPL_MASK = 32'hffff_ffff
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register write port
  input  wire logic        wr_clear,
  input  wire logic        wr_set,
  input  wire logic [31:0] wr_data,
  // Protection state
  output logic      [31:0] protect_ff
);
  logic [31:0] nxt_protect;
  // Ones set or clear, zeros leave the bit alone; unimplemented bits stay zero
  always_comb begin
    nxt_protect = protect_ff;
    if (wr_clear) begin
      nxt_protect = protect_ff & ~wr_data;
    end
    if (wr_set) begin
      nxt_protect = protect_ff | wr_data;
    end
    nxt_protect = nxt_protect & IMPL_MASK;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      protect_ff <= RESET_VAL;
    end else begin
      protect_ff <= nxt_protect;
    end
  end
endmodule

/* File: rtl/abwp_strobe_gen.sv */
// Byte lane strobe generator for sparse transfers
`timescale 1ns/1ps
module abwp_strobe_gen (
  // Transfer shape
  input  wire logic [1:0] addr_lo,
  input  wire logic [2:0] size,
  // Lanes
  output logic      [3:0] strobe
);
  // Byte, half-word or word lane select; larger sizes fall back to the word
  always_comb begin
    case (size)
      3'h0:    strobe = 4'h1 << addr_lo;
      3'h1:    strobe = addr_lo[1] ? 4'hc : 4'h3;
      default: strobe = 4'hf;
    endcase
  end
endmodule

/* File: test/abwp_apb_model.sv */
// APB4 peripheral model with wait states, error address and lane capture
`timescale 1ns/1ps
module abwp_apb_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB4 request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] paddr,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [2:0]  pprot,
  // APB4 answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bench control and observation
  input  wire logic [3:0]  wait_n,
  input  wire logic [31:0] err_addr,
  output logic      [3:0]  last_strb,
  output logic      [2:0]  last_prot,
  output logic      [7:0]  wr_count,
  output logic             setup_seen
);
  logic [31:0] mem [16];
  logic [3:0]  wcnt_ff;
  logic [31:0] last_rd_ff;
  assign pready  = psel && penable && (wcnt_ff == wait_n);
  assign pslverr = pready && (paddr == err_addr);
  // Idle data flips so a stale value never passes for a fresh one
  assign prdata  = pready ? mem[paddr[5:2]] : ~last_rd_ff;
  // Wait-state counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !(psel && penable) || pready) begin
      wcnt_ff <= 4'h0;
    end else begin
      wcnt_ff <= wcnt_ff + 4'h1;
    end
  end
  // Lane-wise storage and capture of each completed transfer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_rd_ff <= 32'h0;
      wr_count   <= 8'h0;
      setup_seen <= 1'b0;
    end else begin
      if (psel && !penable) setup_seen <= 1'b1;
      if (pready) begin
        last_rd_ff <= prdata;
        last_strb  <= pstrb;
        last_prot  <= pprot;
        if (pwrite && !pslverr) begin
          wr_count <= wr_count + 8'h1;
          for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) mem[paddr[5:2]][8*i+:8] <= pwdata[8*i+:8];
          end
        end
      end
    end
  end
endmodule

/* File: test/abwp_bridge_test.sv */
// Self-checking bench for the bridge with write protection
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module abwp_bridge_test;
  import abwp_pkg::*;
  localparam logic [31:0] CA = 32'h4000_0000;
  localparam logic [31:0] CC = 32'h4200_0000;
  logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, psel, penable, pwrite;
  logic        pready, pslverr, setup_seen, e;
  logic [31:0] haddr, hwdata, hrdata, paddr, pwdata, prdata, err_addr, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pprot, last_prot;
  logic [3:0]  hprot, pstrb, wait_n, last_strb;
  logic [7:0]  wr_count;
  wire         hready = hreadyout;
  int          bad_count, total_checks, lat;
  int          cbits[6] = '{1, 7, 8, 15, 16, 19};
  int          abits[4] = '{1, 2, 3, 6};

  abwp_bridge uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .psel(psel),
    .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  abwp_apb_model far (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_n(wait_n),
    .err_addr(err_addr), .last_strb(last_strb), .last_prot(last_prot),
    .wr_count(wr_count), .setup_seen(setup_seen));

  task automatic summarize;
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One AHB transfer: address phase, then data phase held until ready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [2:0] s,
                     input logic [31:0] d, output logic [31:0] rdv, output logic rsp);
    @(posedge sys_clk);
    #1;
    hsel = 1'b1;
    htrans = ABWP_HTRANS_NONSEQ;
    haddr = a;
    hwrite = w;
    hsize = s;
    @(posedge sys_clk);
    #1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwdata = d;
    lat = 0;
    while (hreadyout !== 1'b1) begin
      if (lat == 40) begin
        bad_count++;
        summarize();
      end
      @(posedge sys_clk);
      #1;
      lat++;
    end
    rdv = hrdata;
    rsp = hresp;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic exp_err);
    ahb(1'b1, a, 3'h2, d, r, e);
    `CHK(e, exp_err)
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 3'h2, 32'h0, r, e);
    `CHK(e, 1'b0)
    `CHK(r, exp)
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    hprot = 4'h3;
    wait_n = 4'h0;
    err_addr = 32'h0;
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rd(CA, ABWP_RST_GROUP_A);
    rd(CA + 32'h4, ABWP_RST_GROUP_A);
    rd(CC, ABWP_RST_GROUP_C);
    wr(CA + 32'h400, 32'h1, 1'b1);
    `CHK(wr_count, 8'h0)
    wr(CA, 32'h0, 1'b0);
    rd(CA + 32'h4, ABWP_RST_GROUP_A);
    wr(CA, 32'h2, 1'b0);
    rd(CA, 32'h0);
    wr(CA + 32'h400, 32'h1234_5678, 1'b0);
    `CHK(lat, 1)
    rd(CA + 32'h400, 32'h1234_5678);
    `CHK(setup_seen, 1'b0)
    `CHK(last_prot & 3'b101, 3'b001)
    wr(CA + 32'h4, ABWP_MASK_GROUP_A, 1'b0);
    rd(CA, ABWP_MASK_GROUP_A);
    foreach (abits[i]) wr(CA + (abits[i] << 10), 32'h0, 1'b1);
    wr(CA, ABWP_MASK_GROUP_A, 1'b0);
    foreach (cbits[i]) begin
      wr(CC + 32'h4, 32'h1 << cbits[i], 1'b0);
      rd(CC, ABWP_RST_GROUP_C | (32'h1 << cbits[i]));
      wr(CC + (cbits[i] << 10), 32'h0, 1'b1);
      wr(CC, 32'h1 << cbits[i], 1'b0);
      wr(CC + (cbits[i] << 10), 32'h0, 1'b0);
    end
    // Slow peripheral, then an error answer from it
    wait_n = 4'h3;
    wr(CA + 32'hc00, 32'hcafe_f00d, 1'b0);
    `CHK(lat, 4)
    ahb(1'b1, CA + 32'hc01, 3'h0, 32'h0000_ab00, r, e);
    `CHK(last_strb, 4'b0010)
    ahb(1'b0, CA + 32'hc02, 3'h1, 32'h0, r, e);
    `CHK(last_strb, 4'b1100)
    `CHK(r, 32'hcafe_ab0d)
    err_addr = CA + 32'hc00;
    wr(CA + 32'hc00, 32'h0, 1'b1);
    wait_n = 4'h0;
    // Second reset in mid-run restores protection
    sys_rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    rd(CA, ABWP_RST_GROUP_A);
    summarize();
  end
endmodule
